// ===== tb/dpm_dev_model.sv
// behavioural model of one port of the dual-port memory
module dpm_dev_model (
  input  wire logic        clk_i,
  input  wire logic [14:0] addr_i,
  input  wire logic        sel_n_i,
  input  wire logic        sem_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [1:0]  lane_n_i,
  input  wire logic [15:0] wd_i,
  input  wire logic        busy_n_i,
  input  wire logic        peer_mbox_i,
  input  wire logic        peer_hold_i,
  output logic      [15:0] rd_o,
  output logic             irq_n_o,
  output logic             peer_irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // array, latches
  // ****************
  logic [15:0] mem [0:32767];
  logic [7:0]  semaphore_select_n = 8'hff;
  logic [15:0] last = 16'h0000;
  logic        act = 1'b0;
  // peer side holds latch 6 while peer_hold_i is high
  logic        pend = 1'b0;
  logic        peer_q = 1'b0;
  logic        ps;
  logic [14:0] pa;
  logic [15:0] pd;
  logic [1:0]  pl;
  logic        wr_act;
  logic        rd_act;
  assign wr_act = !wr_n_i && (sel_n_i != sem_n_i);
  assign rd_act = !oe_n_i && wr_n_i && (sel_n_i != sem_n_i);
  initial irq_n_o = 1'b1;
  initial peer_irq_o = 1'b0;
  always_comb begin
    // released lanes toggle, so a stale value never reads as good
    rd_o = ~last;
    if (rd_act && !sem_n_i) rd_o = {16{semaphore_select_n[addr_i[2:0]]}};
    else if (rd_act) begin
      if (!lane_n_i[1]) rd_o[15:8] = mem[addr_i][15:8];
      if (!lane_n_i[0]) rd_o[7:0] = mem[addr_i][7:0];
    end
    if (oe_n_i) rd_o = ~last;
  end
  always @(posedge clk_i) begin
    last <= rd_o;
    act <= wr_act;
    peer_q <= peer_hold_i;
    if (wr_act) {pa, pd, pl, ps} <= {addr_i, wd_i, lane_n_i, !sem_n_i};
    if (act && !wr_act && busy_n_i) begin
      // a request against a held latch is only recorded
      if (ps && pa[2:0] == 3'h6 && peer_hold_i) pend <= !pd[0];
      else if (ps) semaphore_select_n[pa[2:0]] <= pd[0];
      else begin
        if (!pl[1]) mem[pa][15:8] <= pd[15:8];
        if (!pl[0]) mem[pa][7:0] <= pd[7:0];
      end
      if (!ps && pa == 15'h7fff) peer_irq_o <= 1'b1;
    end
    if (peer_q && !peer_hold_i && pend) begin
      semaphore_select_n[6] <= 1'b0;
      pend <= 1'b0;
    end
    if (rd_act && sem_n_i && addr_i == 15'h7ffe && busy_n_i) irq_n_o <= 1'b1;
    if (peer_mbox_i) irq_n_o <= 1'b0;
  end
endmodule

// ===== tb/dpm_port_ctrl_bench.sv
// testbench for the dual-port memory port controller
module dpm_port_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // stimulus
  // ****************
  localparam dpm_pkg::dpm_op_t ARD = dpm_pkg::DPM_OP_ARRAY_RD;
  localparam dpm_pkg::dpm_op_t AWR = dpm_pkg::DPM_OP_ARRAY_WR;
  localparam dpm_pkg::dpm_op_t SRD = dpm_pkg::DPM_OP_SEM_RD;
  localparam dpm_pkg::dpm_op_t SWR = dpm_pkg::DPM_OP_SEM_WR;
  logic clk = 0, srst = 1, req = 0, busy_n = 1, pmb = 0, seen = 0, phold = 0;
  dpm_pkg::dpm_op_t op = ARD;
  logic [14:0] addr = 15'h0000, a_o;
  logic [15:0] wdata = 16'h0000, rdata, dout, din, rd;
  logic [1:0]  lane = 2'b00;
  logic ready, done, bseen, irq, irq_n, sel_n, sem_n, wr_n, oe_n, ub_n, lb_n, doe, pirq;
  int err_total = 0, checked = 0;
  dpm_port_ctrl dut_u (.clk_i(clk), .srst_i(srst), .req_i(req), .op_i(op), .addr_i(addr),
    .wdata_i(wdata), .lane_i(lane), .ready_o(ready), .done_o(done), .rdata_o(rdata),
    .busy_seen_o(bseen), .mbox_irq_o(irq), .addr_o(a_o), .select_n_o(sel_n),
    .semaphore_select_n_o(sem_n), .write_n_o(wr_n), .out_enable_n_o(oe_n),
    .upper_lane_enable_n_o(ub_n), .lower_lane_enable_n_o(lb_n), .data_o(dout),
    .data_oe_o(doe), .data_i(din), .busy_n_i(busy_n), .irq_n_i(irq_n));
  dpm_dev_model dev_u (.clk_i(clk), .addr_i(a_o), .sel_n_i(sel_n), .sem_n_i(sem_n),
    .wr_n_i(wr_n), .oe_n_i(oe_n), .lane_n_i({ub_n, lb_n}), .wd_i(dout), .busy_n_i(busy_n),
    .peer_mbox_i(pmb), .peer_hold_i(phold), .rd_o(din), .irq_n_o(irq_n), .peer_irq_o(pirq));
  initial forever #5 clk = ~clk;
  task automatic finish_test;
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  // bounded wait; running out ends the run
  task automatic wait_for(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++) @(posedge clk) #1;
    if (s !== 1'b1) begin
      err_total++;
      finish_test;
    end
  endtask
  task automatic issue(input dpm_pkg::dpm_op_t o, input logic [14:0] a, input logic [15:0] w,
                       input logic [1:0] l);
    wait_for(ready, 50);
    op = o;
    addr = a;
    wdata = w;
    lane = l;
    req = 1;
    @(posedge clk) #1 req = 0;
  endtask
  task automatic xfer(input dpm_pkg::dpm_op_t o, input logic [14:0] a, input logic [15:0] w,
                      input logic [1:0] l);
    issue(o, a, w, l);
    wait_for(done, 200);
    rd = rdata;
  endtask
  task automatic scen_lanes;
    xfer(AWR, 15'h0005, 16'h1234, 2'b00);
    xfer(AWR, 15'h0005, 16'habcd, 2'b01);
    xfer(ARD, 15'h0005, 16'h0000, 2'b00);
    chk("both_lanes", 16'hab34, rd);
    xfer(ARD, 15'h0005, 16'h0000, 2'b10);
    chk("lower_lane", 16'h0034, {8'h00, rd[7:0]});
  endtask
  task automatic scen_sem;
    xfer(SWR, 15'h7ff3, 16'hfffe, 2'b00);
    xfer(SRD, 15'h0003, 16'h0000, 2'b00);
    chk("sem_take", 16'h0000, rd);
    xfer(SRD, 15'h0004, 16'h0000, 2'b00);
    chk("sem_other", 16'hffff, rd);
    xfer(SWR, 15'h0003, 16'h0001, 2'b00);
    xfer(SRD, 15'h0003, 16'h0000, 2'b00);
    chk("sem_release", 16'hffff, rd);
    phold = 1;
    xfer(SWR, 15'h0006, 16'h0000, 2'b00);
    xfer(SRD, 15'h0006, 16'h0000, 2'b00);
    chk("sem_peer_held", 16'hffff, rd);
    phold = 0;
    xfer(SRD, 15'h0006, 16'h0000, 2'b00);
    chk("sem_granted", 16'h0000, rd);
  endtask
  task automatic scen_mbox;
    xfer(AWR, 15'h7fff, 16'h00c3, 2'b00);
    chk("peer_irq", 16'h0001, {15'h0000, pirq});
    pmb = 1;
    @(posedge clk) #1 pmb = 0;
    wait_for(irq, 10);
    xfer(ARD, 15'h7fff, 16'h0000, 2'b00);
    chk("irq_peer_rd", 16'h0001, {15'h0000, irq});
    busy_n = 0;
    xfer(ARD, 15'h7ffe, 16'h0000, 2'b00);
    chk("busy_seen", 16'h0001, {15'h0000, bseen});
    chk("irq_busy_rd", 16'h0001, {15'h0000, irq});
    busy_n = 1;
    xfer(ARD, 15'h7ffe, 16'h0000, 2'b00);
    chk("irq_own_rd", 16'h0000, {15'h0000, irq});
  endtask
  task automatic scen_busy_wr;
    busy_n = 0;
    issue(AWR, 15'h0009, 16'h55aa, 2'b00);
    // no strobe may start while busy holds
    repeat (20) @(posedge clk) #1 if (wr_n !== 1'b1) seen = 1;
    chk("stall_wr", 16'h0000, {15'h0000, seen});
    busy_n = 1;
    wait_for(done, 200);
    xfer(ARD, 15'h0009, 16'h0000, 2'b00);
    chk("late_wr", 16'h55aa, rd);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 chk("rst_pins", 16'h007e, {9'h000, sel_n, sem_n, wr_n, oe_n, ub_n, lb_n, doe});
    srst = 0;
    scen_lanes;
    scen_sem;
    scen_mbox;
    scen_busy_wr;
    finish_test;
  end
endmodule

// ===== verilog/dpm_pkg.sv
// types for the dual-port memory port controller
package dpm_pkg;
  typedef enum logic [2:0] {
    DPM_IDLE,
    DPM_SETTLE,
    DPM_STROBE,
    DPM_READ,
    DPM_GAP
  } dpm_state_t;
  typedef enum logic [1:0] {
    DPM_OP_ARRAY_RD,
    DPM_OP_ARRAY_WR,
    DPM_OP_SEM_RD,
    DPM_OP_SEM_WR
  } dpm_op_t;
endpackage

// ===== verilog/dpm_port_ctrl.sv
// host-side controller for one port of the dual-port memory
`include "dpm_regs.svh"

// What this block does
// - waits flowthrough before trusting array read data
// - array reads with select and output enable low
// - write waits for busy to settle
// - semaphore access: semaphore low, select high
// - gap before semaphore read after write
module dpm_port_ctrl #(
  parameter int AW = 15,
  parameter int DW = 16
) (
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   req_i,
  input  wire dpm_pkg::dpm_op_t       op_i,
  input  wire logic [AW-1:0]          addr_i,
  input  wire logic [DW-1:0]          wdata_i,
  input  wire logic [1:0]             lane_i,
  output logic                        ready_o,
  output logic                        done_o,
  output logic [DW-1:0]               rdata_o,
  output logic                        busy_seen_o,
  output logic                        mbox_irq_o,
  output logic [AW-1:0]               addr_o,
  output logic                        select_n_o,
  output logic                        semaphore_select_n_o,
  output logic                        write_n_o,
  output logic                        out_enable_n_o,
  output logic                        upper_lane_enable_n_o,
  output logic                        lower_lane_enable_n_o,
  output logic [DW-1:0]               data_o,
  output logic                        data_oe_o,
  input  wire logic [DW-1:0]          data_i,
  input  wire logic                   busy_n_i,
  input  wire logic                   irq_n_i
);
  localparam int CW = 8;

  // ************************************************************
  // pin input synchronisers
  // ************************************************************
  logic [DW-1:0] data_s1, data_s2;
  logic          busy_s1, busy_s2, irq_s1, irq_s2;
  always_ff @(posedge clk_i) begin
    data_s1 <= data_i;
    data_s2 <= data_s1;
    busy_s1 <= busy_n_i;
    busy_s2 <= busy_s1;
    irq_s1  <= irq_n_i;
    irq_s2  <= irq_s1;
  end

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n);
  endfunction

  // ************************************************************
  // transfer sequencer
  // ************************************************************
  dpm_pkg::dpm_state_t state, next_state;
  dpm_pkg::dpm_op_t    op, next_op;
  logic [CW-1:0]       cnt, next_cnt;
  logic [AW-1:0]       next_addr;
  logic [DW-1:0]       next_data, next_rdata;
  logic [1:0]          lane, next_lane;
  logic next_ready, next_done, next_sel, next_sem, next_wr, next_oe, next_doe, next_busy_seen;
  logic is_sem, is_wr;

  assign is_sem = (op == dpm_pkg::DPM_OP_SEM_RD) || (op == dpm_pkg::DPM_OP_SEM_WR);
  assign is_wr  = (op == dpm_pkg::DPM_OP_ARRAY_WR) || (op == dpm_pkg::DPM_OP_SEM_WR);

  always_comb begin
    next_state     = state;
    next_op        = op;
    next_cnt       = cnt;
    next_addr      = addr_o;
    next_data      = data_o;
    next_rdata     = rdata_o;
    next_lane      = lane;
    next_ready     = 1'b0;
    next_done      = 1'b0;
    next_sel       = select_n_o;
    next_sem       = semaphore_select_n_o;
    next_wr        = write_n_o;
    next_oe        = out_enable_n_o;
    next_doe       = data_oe_o;
    next_busy_seen = busy_seen_o;
    unique case (state)
      dpm_pkg::DPM_IDLE: begin
        next_ready = 1'b1;
        if (req_i && ready_o) begin
          next_ready = 1'b0;
          next_op    = op_i;
          next_addr  = addr_i;
          next_lane  = lane_i;
          next_busy_seen = 1'b0;
          if (op_i == dpm_pkg::DPM_OP_SEM_WR) begin
            // only bit 0 matters; drive it on all lines anyway
            next_data = {DW{wdata_i[0]}};
          end else begin
            next_data = wdata_i;
          end
          if (op_i == dpm_pkg::DPM_OP_SEM_RD || op_i == dpm_pkg::DPM_OP_SEM_WR) begin
            // semaphore cycle: array select stays high, lanes high
            next_sel  = 1'b1;
            next_sem  = 1'b0;
            next_lane = 2'b11;
          end else begin
            next_sel = 1'b0;
            next_sem = 1'b1;
          end
          next_state = dpm_pkg::DPM_SETTLE;
          next_cnt   = cyc(`DPM_BUSY_CYC);
        end
      end
      dpm_pkg::DPM_SETTLE: begin
        // address and select held until busy can settle
        if (cnt > cyc(1)) begin
          next_cnt = cnt - cyc(1);
        end else if (is_wr && !busy_s2) begin
          // busy low: hold the write back, retry when it clears
          next_busy_seen = 1'b1;
        end else if (is_wr) begin
          next_wr    = 1'b0;
          next_doe   = 1'b1;
          next_state = dpm_pkg::DPM_STROBE;
          next_cnt   = cyc(`DPM_SETUP_CYC);
        end else begin
          if (!busy_s2) begin
            next_busy_seen = 1'b1;
          end
          next_oe    = 1'b0;
          next_state = dpm_pkg::DPM_READ;
          next_cnt   = cyc(`DPM_ACCESS_CYC);
        end
      end
      dpm_pkg::DPM_STROBE: begin
        if (cnt > cyc(1)) begin
          next_cnt = cnt - cyc(1);
        end else begin
          // rising strobe commits the word
          next_wr    = 1'b1;
          next_sel   = 1'b1;
          next_sem   = 1'b1;
          next_lane  = 2'b11;
          next_state = dpm_pkg::DPM_GAP;
          next_cnt   = cyc(`DPM_FLAG_GAP_CYC);
        end
      end
      dpm_pkg::DPM_READ: begin
        if (cnt > cyc(1)) begin
          next_cnt = cnt - cyc(1);
        end else begin
          next_rdata = data_s2;
          next_oe    = 1'b1;
          next_sel   = 1'b1;
          next_sem   = 1'b1;
          next_lane  = 2'b11;
          next_done  = 1'b1;
          next_state = dpm_pkg::DPM_GAP;
          next_cnt   = cyc(`DPM_FLAG_GAP_CYC);
        end
      end
      dpm_pkg::DPM_GAP: begin
        // release bus, then rest before the next semaphore read
        next_doe = 1'b0;
        if (cnt > cyc(1)) begin
          next_cnt = cnt - cyc(1);
        end else begin
          if (is_wr) begin
            next_done = 1'b1;
          end
          next_state = dpm_pkg::DPM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state                 <= dpm_pkg::DPM_IDLE;
      op                    <= dpm_pkg::DPM_OP_ARRAY_RD;
      cnt                   <= '0;
      addr_o                <= '0;
      data_o                <= '0;
      rdata_o               <= '0;
      lane                  <= 2'b11;
      ready_o               <= 1'b0;
      done_o                <= 1'b0;
      select_n_o            <= 1'b1;
      semaphore_select_n_o  <= 1'b1;
      write_n_o             <= 1'b1;
      out_enable_n_o        <= 1'b1;
      data_oe_o             <= 1'b0;
      busy_seen_o           <= 1'b0;
    end else begin
      state                 <= next_state;
      op                    <= next_op;
      cnt                   <= next_cnt;
      addr_o                <= next_addr;
      data_o                <= next_data;
      rdata_o               <= next_rdata;
      lane                  <= next_lane;
      ready_o               <= next_ready;
      done_o                <= next_done;
      select_n_o            <= next_sel;
      semaphore_select_n_o  <= next_sem;
      write_n_o             <= next_wr;
      out_enable_n_o        <= next_oe;
      data_oe_o             <= next_doe;
      busy_seen_o           <= next_busy_seen;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      upper_lane_enable_n_o <= 1'b1;
      lower_lane_enable_n_o <= 1'b1;
      mbox_irq_o            <= 1'b0;
    end else begin
      upper_lane_enable_n_o <= next_lane[1];
      lower_lane_enable_n_o <= next_lane[0];
      // device interrupt is active low; mailbox flag for this port
      mbox_irq_o            <= !irq_s2;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  write_commit_a: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(write_n_o) |-> $past(state) == dpm_pkg::DPM_STROBE)
    else $error("write strobe rose outside strobe phase");
  sem_not_array_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !semaphore_select_n_o |-> select_n_o)
    else $error("array and semaphore select low together");
  read_enable_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !out_enable_n_o |-> (!select_n_o || !semaphore_select_n_o) && write_n_o)
    else $error("output enable low without a read select");
  no_drive_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !out_enable_n_o |-> !data_oe_o)
    else $error("driving data while device outputs enabled");
  flag_gap_a: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(write_n_o) |-> semaphore_select_n_o [*2])
    else $error("semaphore reselected too soon after write");
  busy_block_a: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(write_n_o) |-> $past(busy_s2))
    else $error("write strobe started while busy low");
  sem_path_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (state != dpm_pkg::DPM_IDLE) && is_sem |-> select_n_o && upper_lane_enable_n_o
      && lower_lane_enable_n_o)
    else $error("array select or lanes low in semaphore cycle");
endmodule

// ===== verilog/dpm_regs.svh
// timing counts and address constants for the dual-port memory port controller
`ifndef DPM_REGS_SVH
`define DPM_REGS_SVH
// clock period in ns
`define DPM_CLK_NS          10
// least times in ns (plain defaults)
`define DPM_ACCESS_NS       25
`define DPM_FLOWTHRU_NS     30
`define DPM_BUSY_SETTLE_NS  20
`define DPM_DATA_SETUP_NS   15
`define DPM_FLAG_PULSE_NS   12
`define DPM_FLAG_W2R_NS     5
// cycle counts, least times rounded up
`define DPM_CYC(ns) ((((ns) + `DPM_CLK_NS - 1) / `DPM_CLK_NS) < 1 ? 1 : \
  (((ns) + `DPM_CLK_NS - 1) / `DPM_CLK_NS))
`define DPM_ACCESS_CYC      `DPM_CYC(`DPM_ACCESS_NS + `DPM_FLOWTHRU_NS)
`define DPM_BUSY_CYC        `DPM_CYC(`DPM_BUSY_SETTLE_NS)
`define DPM_SETUP_CYC       `DPM_CYC(`DPM_DATA_SETUP_NS)
`define DPM_FLAG_GAP_CYC    `DPM_CYC(`DPM_FLAG_PULSE_NS + `DPM_FLAG_W2R_NS)
// mailbox word offsets below the top address
`define DPM_MBOX_RIGHT_OFS  0
`define DPM_MBOX_LEFT_OFS   1
// semaphore index width
`define DPM_SEM_BITS        3
`endif
